// File: aft_pkg.sv
// Constants and types shared by the target flow, status and strobe logic.
// Assumes nothing beyond a SystemVerilog compiler; no clock or reset here.
`default_nettype none

package aft_pkg;

    // Work kinds that the core hands over to the link side
    typedef enum logic [2:0] {
        K_LP_RD   = 3'h0,
        K_HP_RD   = 3'h1,
        K_LP_WR   = 3'h2,
        K_HP_WR   = 3'h3,
        K_FAST_WR = 3'h4,
        K_START   = 3'h7
    } aft_kind_type;

    // Arbiter status codes qualified by the grant
    localparam logic [2:0] ST_LP_RD = 3'h0;
    localparam logic [2:0] ST_HP_RD = 3'h1;
    localparam logic [2:0] ST_LP_WR = 3'h2;
    localparam logic [2:0] ST_HP_WR = 3'h3;
    localparam logic [2:0] ST_START = 3'h7;
    localparam logic [2:0] ST_RESET = 3'h7;

    // Link cycles in one data block
    localparam int unsigned BLOCK_CLKS = 4;

    // Inbound strobe pair indices
    localparam int IDX_AD_LO = 0;
    localparam int IDX_AD_HI = 1;
    localparam int IDX_SB = 2;
    localparam int N_IN_STB = 3;

    // Link sequencer states
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_DATA = 2'b01
    } aft_lstate_type;

endpackage

`default_nettype wire

// File: aft_hs_if.sv
// Handshake carrier between the core domain and the link domain.
// Assumes launch and finish are one-cycle pulses of their own domains.
`timescale 1ns/1ps
`default_nettype none

interface aft_hs_if;
    logic launch;
    logic arrive;
    logic finish;
    logic retire;

    // Core side starts work and sees it retire
    modport core (output launch, input retire);
    // Link side sees work arrive and reports it finished
    modport link (input arrive, output finish);
    // Crossing logic in between
    modport cdc (input launch, input finish, output arrive, output retire);
endinterface

`default_nettype wire

// File: aft_hs_cdc.sv
// Toggle handshake that carries launch and finish pulses between domains.
// Assumes a pulse is not relaunched before the previous one has retired.
`timescale 1ns/1ps
`default_nettype none

module aft_hs_cdc (
    input wire logic clk,
    input wire logic link_clk,
    input wire logic arst_n,
    aft_hs_if.cdc hs
);
    logic src_tgl_q;
    logic [2:0] dst_sync_q;
    logic dst_tgl_q;
    logic [2:0] src_sync_q;
    logic arrive_q;
    logic retire_q;

    ////////////////////////////////////////////////////////////////////
    // Core domain: flip on launch, watch the returning toggle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_tgl_q <= 1'b0;
            src_sync_q <= 3'h0;
            retire_q <= 1'b0;
        end else begin
            src_tgl_q <= src_tgl_q ^ hs.launch;
            src_sync_q <= {src_sync_q[1:0], dst_tgl_q};
            // Edge taken on stages two and three only
            retire_q <= src_sync_q[2] ^ src_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link domain: flip on finish, watch the launch toggle
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            dst_tgl_q <= 1'b0;
            dst_sync_q <= 3'h0;
            arrive_q <= 1'b0;
        end else begin
            dst_tgl_q <= dst_tgl_q ^ hs.finish;
            dst_sync_q <= {dst_sync_q[1:0], src_tgl_q};
            arrive_q <= dst_sync_q[2] ^ dst_sync_q[1];
        end
    end

    assign hs.arrive = arrive_q;
    assign hs.retire = retire_q;
endmodule

`default_nettype wire

// File: aft_target.sv
// Target-side flow control, arbiter status and data strobes of a graphics
// expansion port; core work requests cross into the port's own clock.
// Assumes link_clk is the bus clock and all pins are sampled on it.
//
// Summary of operation
// - Low priority read data is held back while the read buffer is full; high priority reads still go.
// - The read-buffer-full input is looked at only when a transfer starts, never during one.
// - Fast write data is not driven while the write buffer is full.
// - The write-buffer-full input is looked at only when a transfer starts.
// - A 3-bit status code is always driven and only means something while the grant is low.
// - Code 000 returns low priority read data and 001 returns high priority read data.
// - Codes 010 and 011 ask the master for low and high priority write data.
// - Code 111 with grant lets the master start a bus transaction.
// - The low data strobe times the low data half and is driven by whoever supplies data.
// - The high data strobe times the high data half and is driven by whoever supplies data.
// - Each data strobe complement takes part only in 4X transfers.
`timescale 1ns/1ps
`default_nettype none

module aft_target import aft_pkg::*; #(
    parameter int unsigned XFER_CLKS = BLOCK_CLKS,
    parameter bit RD_FULL_IMPL = 1'b1,
    parameter bit WR_FULL_IMPL = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic req_valid,
    input wire aft_kind_type req_kind,
    output logic req_ready,
    output logic xfer_done,
    input wire logic mode_4x,
    input wire logic sb_rate_en,
    input wire logic rd_buf_full_n,
    input wire logic wr_buf_full_n,
    output logic [2:0] arb_status_code,
    output logic bus_grant_n,
    input wire logic ad_strobe_lo_i,
    output logic ad_strobe_lo_o,
    output logic ad_strobe_lo_oe,
    input wire logic ad_strobe_lo_comp_i,
    output logic ad_strobe_lo_comp_o,
    output logic ad_strobe_lo_comp_oe,
    input wire logic ad_strobe_hi_i,
    output logic ad_strobe_hi_o,
    output logic ad_strobe_hi_oe,
    input wire logic ad_strobe_hi_comp_i,
    output logic ad_strobe_hi_comp_o,
    output logic ad_strobe_hi_comp_oe,
    input wire logic sideband_strobe,
    input wire logic sideband_strobe_comp,
    output logic [2:0] strobe_seen
);
    localparam int CW = $clog2(XFER_CLKS + 1);

    // Device supplies the data for read returns and fast writes
    function automatic logic dev_sources(input aft_kind_type k);
        dev_sources = (k == K_LP_RD) || (k == K_HP_RD) || (k == K_FAST_WR);
    endfunction

    // Whether a pending kind must wait on the sampled buffer flags
    function automatic logic is_blocked(input aft_kind_type k, input logic rdf, input logic wrf);
        is_blocked = ((k == K_LP_RD) && rdf) || ((k == K_FAST_WR) && wrf);
    endfunction

    aft_hs_if hs();

    logic ready_q;
    logic done_q;
    logic launch_q;
    aft_kind_type ckind_q;

    logic rdf_m_q;
    logic rdf_s_q;
    logic wrf_m_q;
    logic wrf_s_q;
    logic m4x_m_q;
    logic m4x_s_q;
    logic sben_m_q;
    logic sben_s_q;
    logic rd_full;
    logic wr_full;

    aft_lstate_type state_q;
    aft_kind_type lkind_q;
    logic pend_q;
    logic [CW-1:0] cnt_q;
    logic grant_n_q;
    logic [2:0] code_q;
    logic fin_q;

    logic [1:0] stb_q;
    logic [1:0] stb_oe_q;
    logic [1:0] comp_oe_q;
    logic [1:0] stb_c_q;

    logic [N_IN_STB-1:0] in_t;
    logic [N_IN_STB-1:0] in_c;
    logic [N_IN_STB-1:0] gate;
    logic [N_IN_STB-1:0] seen_q;
    logic [3:0] wwin_q;

    ////////////////////////////////////////////////////////////////////
    // Core domain: accept one request at a time, hold its kind stable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_q <= 1'b1;
            launch_q <= 1'b0;
            done_q <= 1'b0;
            ckind_q <= K_START;
        end else begin
            launch_q <= 1'b0;
            done_q <= hs.retire;
            if (req_valid && ready_q) begin
                ckind_q <= req_kind;
                launch_q <= 1'b1;
                ready_q <= 1'b0;
            end else if (hs.retire) begin
                ready_q <= 1'b1;
            end
        end
    end

    assign hs.launch = launch_q;
    assign hs.finish = fin_q;
    assign req_ready = ready_q;
    assign xfer_done = done_q;

    // Pulses cross by toggle; ckind_q is only read after arrive
    aft_hs_cdc u_hs (
        .clk(clk),
        .link_clk(link_clk),
        .arst_n(arst_n),
        .hs(hs)
    );

    ////////////////////////////////////////////////////////////////////
    // Link domain synchronisers for pins and core-side mode levels
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdf_m_q <= 1'b1;
            rdf_s_q <= 1'b1;
            wrf_m_q <= 1'b1;
            wrf_s_q <= 1'b1;
            m4x_m_q <= 1'b0;
            m4x_s_q <= 1'b0;
            sben_m_q <= 1'b0;
            sben_s_q <= 1'b0;
        end else begin
            rdf_m_q <= rd_buf_full_n;
            rdf_s_q <= rdf_m_q;
            wrf_m_q <= wr_buf_full_n;
            wrf_s_q <= wrf_m_q;
            m4x_m_q <= mode_4x;
            m4x_s_q <= m4x_m_q;
            sben_m_q <= sb_rate_en;
            sben_s_q <= sben_m_q;
        end
    end

    // An absent flag pin counts as never full
    assign rd_full = RD_FULL_IMPL && !rdf_s_q;
    assign wr_full = WR_FULL_IMPL && !wrf_s_q;

    ////////////////////////////////////////////////////////////////////
    // Link sequencer: flags are judged only in idle, at a cycle start
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= LS_IDLE;
            lkind_q <= K_START;
            pend_q <= 1'b0;
            cnt_q <= '0;
            grant_n_q <= 1'b1;
            code_q <= ST_RESET;
            fin_q <= 1'b0;
            wwin_q <= 4'h0;
        end else begin
            fin_q <= 1'b0;
            grant_n_q <= 1'b1;
            wwin_q <= {wwin_q[2:0], (state_q == LS_DATA) && !dev_sources(lkind_q)};
            case (state_q)
                LS_IDLE: begin
                    if (hs.arrive) begin
                        pend_q <= 1'b1;
                        lkind_q <= ckind_q;
                    end else if (pend_q && !is_blocked(lkind_q, rd_full, wr_full)) begin
                        pend_q <= 1'b0;
                        if (lkind_q != K_FAST_WR) begin
                            grant_n_q <= 1'b0;
                            code_q <= lkind_q;
                        end
                        if (lkind_q == K_START) begin
                            fin_q <= 1'b1;
                        end else begin
                            state_q <= LS_DATA;
                            cnt_q <= CW'(XFER_CLKS);
                        end
                    end
                end
                LS_DATA: begin
                    // Flags are not looked at here
                    cnt_q <= cnt_q - CW'(1);
                    if (cnt_q == CW'(1)) begin
                        state_q <= LS_IDLE;
                        fin_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= LS_IDLE;
                end
            endcase
        end
    end

    assign arb_status_code = code_q;
    assign bus_grant_n = grant_n_q;

    ////////////////////////////////////////////////////////////////////
    // Outbound strobes, one per data half; lag the data phase by a cycle
    for (genvar h = 0; h < 2; h++) begin : g_out_stb
        always_ff @(posedge link_clk or negedge arst_n) begin
            if (!arst_n) begin
                stb_q[h] <= 1'b0;
                stb_c_q[h] <= 1'b1;
                stb_oe_q[h] <= 1'b0;
                comp_oe_q[h] <= 1'b0;
            end else if (state_q == LS_DATA && dev_sources(lkind_q)) begin
                stb_q[h] <= ~stb_q[h];
                stb_c_q[h] <= stb_q[h];
                stb_oe_q[h] <= 1'b1;
                comp_oe_q[h] <= m4x_s_q;
            end else begin
                stb_q[h] <= 1'b0;
                stb_c_q[h] <= 1'b1;
                stb_oe_q[h] <= 1'b0;
                comp_oe_q[h] <= 1'b0;
            end
        end
    end

    // Complement is the inverse level; only enabled in 4X
    assign ad_strobe_lo_o = stb_q[IDX_AD_LO];
    assign ad_strobe_lo_oe = stb_oe_q[IDX_AD_LO];
    assign ad_strobe_lo_comp_o = stb_c_q[IDX_AD_LO];
    assign ad_strobe_lo_comp_oe = comp_oe_q[IDX_AD_LO];
    assign ad_strobe_hi_o = stb_q[IDX_AD_HI];
    assign ad_strobe_hi_oe = stb_oe_q[IDX_AD_HI];
    assign ad_strobe_hi_comp_o = stb_c_q[IDX_AD_HI];
    assign ad_strobe_hi_comp_oe = comp_oe_q[IDX_AD_HI];

    ////////////////////////////////////////////////////////////////////
    // Inbound strobes from the master: data halves on writes, sideband
    assign in_t = {sideband_strobe, ad_strobe_hi_i, ad_strobe_lo_i};
    assign in_c = {sideband_strobe_comp, ad_strobe_hi_comp_i, ad_strobe_lo_comp_i};
    // Master edges trail its data phase by turnaround plus the sync stages
    assign gate[IDX_AD_LO] = wwin_q[3];
    assign gate[IDX_AD_HI] = wwin_q[3];
    assign gate[IDX_SB] = sben_s_q;

    for (genvar s = 0; s < N_IN_STB; s++) begin : g_in_stb
        logic [2:0] t_q;
        logic [1:0] c_q;
        always_ff @(posedge link_clk or negedge arst_n) begin
            if (!arst_n) begin
                t_q <= 3'h7;
                c_q <= 2'h3;
                seen_q[s] <= 1'b0;
            end else begin
                t_q <= {t_q[1:0], in_t[s]};
                c_q <= {c_q[0], in_c[s]};
                // In 4X an edge counts only when the pair is differential
                seen_q[s] <= gate[s] && (t_q[2] ^ t_q[1]) && (!m4x_s_q || (c_q[1] != t_q[1]));
            end
        end
    end

    assign strobe_seen = seen_q;

    ////////////////////////////////////////////////////////////////////
    // Checks on the link side
    sequence s_lp_rd_held;
        (state_q == LS_IDLE) && pend_q && !hs.arrive && (lkind_q == K_LP_RD) && rd_full;
    endsequence

    sequence s_grant_then_drop(logic [2:0] c);
        (!grant_n_q && code_q == c) ##1 grant_n_q;
    endsequence

    lp_rd_block_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        s_lp_rd_held |=> grant_n_q && (state_q == LS_IDLE) && pend_q)
        else $error("low priority read returned while read buffer full");

    hp_rd_go_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        ((state_q == LS_IDLE) && pend_q && !hs.arrive && lkind_q == K_HP_RD) |=> s_grant_then_drop(ST_HP_RD))
        else $error("high priority read not granted with code 001");

    data_hold_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        ((state_q == LS_DATA) && (cnt_q != CW'(1))) |=> (state_q == LS_DATA) && grant_n_q)
        else $error("transfer disturbed in mid cycle");

    fw_block_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        ((state_q == LS_IDLE) && pend_q && !hs.arrive && lkind_q == K_FAST_WR && wr_full)
        |=> (state_q == LS_IDLE) ##1 !stb_oe_q[IDX_AD_LO] && !stb_oe_q[IDX_AD_HI])
        else $error("fast write strobes driven while write buffer full");

    code_legal_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        !grant_n_q |-> (code_q[2] == 1'b0) || (code_q == ST_START))
        else $error("reserved status code given with grant");

    wr_master_src_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        (!grant_n_q && (code_q == ST_LP_WR || code_q == ST_HP_WR)) |-> ##2 !stb_oe_q[0] && !stb_oe_q[1])
        else $error("device drove strobe while master supplies write data");

    start_grant_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        ((state_q == LS_IDLE) && pend_q && !hs.arrive && lkind_q == K_START)
        |=> s_grant_then_drop(ST_START) and (fin_q ##1 (state_q == LS_IDLE)))
        else $error("start permission not a single grant with code 111");

    comp_4x_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        (comp_oe_q != 2'h0) |-> $past(m4x_s_q) && (comp_oe_q == stb_oe_q))
        else $error("strobe complement driven outside 4X");

    sb_gate_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        seen_q[IDX_SB] |-> $past(sben_s_q))
        else $error("sideband strobe taken before rate configured");

    resume_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        (s_lp_rd_held ##1 ((state_q == LS_IDLE) && pend_q && !rd_full))
        |=> !grant_n_q && (code_q == ST_LP_RD) ##1 (state_q == LS_DATA))
        else $error("queued read not resumed when buffer freed");

    no_full_pin_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        (!RD_FULL_IMPL |-> !rd_full) and (!WR_FULL_IMPL |-> !wr_full))
        else $error("absent buffer-full pin treated as full");

    block_len_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(state_q == LS_DATA) |-> (cnt_q == CW'(XFER_CLKS)) ##1 (state_q == LS_DATA))
        else $error("data block length wrong");
endmodule

`default_nettype wire

// File: aft_master_model.sv
// Behavioural graphics master facing the target: buffer flags, write strobes, sideband strobe.
// Assumes the bench commands flags and sideband bursts; s/t/s lines are pulled up when released.
`timescale 1ns/1ps
`default_nettype none

module aft_master_model import aft_pkg::*; #(
    parameter int unsigned BURST = 4
) (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic bus_grant_n,
    input wire logic [2:0] arb_status_code,
    input wire logic mode_4x,
    input wire logic rd_full_cmd,
    input wire logic wr_full_cmd,
    input wire logic sb_go,
    input wire logic lo_o,
    input wire logic lo_oe,
    input wire logic lo_c_o,
    input wire logic lo_c_oe,
    input wire logic hi_o,
    input wire logic hi_oe,
    input wire logic hi_c_o,
    input wire logic hi_c_oe,
    output logic rd_buf_full_n,
    output logic wr_buf_full_n,
    output logic lo_pin,
    output logic lo_c_pin,
    output logic hi_pin,
    output logic hi_c_pin,
    output logic sb_pin,
    output logic sb_c_pin
);
    logic [3:0] wr_left_q;
    logic [3:0] sb_left_q;
    logic wr_val_q;
    logic sb_val_q;
    logic sb_go_q;

    ////////////////////////////////////////////////////////////////////////
    // Flags follow the bench at link edges; full is low
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_buf_full_n <= 1'b1;
            wr_buf_full_n <= 1'b1;
        end else begin
            rd_buf_full_n <= !rd_full_cmd;
            wr_buf_full_n <= !wr_full_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write source after a write grant; last level held a cycle, so release adds no edge
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_left_q <= 4'h0;
            wr_val_q <= 1'b1;
        end else if (!bus_grant_n && (arb_status_code == 3'h2 || arb_status_code == 3'h3)) begin
            wr_left_q <= BURST[3:0] + 4'h1;
        end else if (wr_left_q != 4'h0) begin
            wr_left_q <= wr_left_q - 4'h1;
            if (wr_left_q != 4'h1) wr_val_q <= ~wr_val_q;
        end
    end

    // Sideband burst on each rising command
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            sb_left_q <= 4'h0;
            sb_val_q <= 1'b1;
            sb_go_q <= 1'b0;
        end else begin
            sb_go_q <= sb_go;
            if (sb_go && !sb_go_q) begin
                sb_left_q <= BURST[3:0] + 4'h1;
            end else if (sb_left_q != 4'h0) begin
                sb_left_q <= sb_left_q - 4'h1;
                if (sb_left_q != 4'h1) sb_val_q <= ~sb_val_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wire levels: whoever sources drives, pull-up otherwise; complement only in 4X
    assign lo_pin = lo_oe ? lo_o : ((wr_left_q != 4'h0) ? wr_val_q : 1'b1);
    assign hi_pin = hi_oe ? hi_o : ((wr_left_q != 4'h0) ? wr_val_q : 1'b1);
    assign lo_c_pin = lo_c_oe ? lo_c_o : ((wr_left_q != 4'h0 && mode_4x) ? ~wr_val_q : 1'b1);
    assign hi_c_pin = hi_c_oe ? hi_c_o : ((wr_left_q != 4'h0 && mode_4x) ? ~wr_val_q : 1'b1);
    assign sb_pin = (sb_left_q != 4'h0) ? sb_val_q : 1'b1;
    assign sb_c_pin = (sb_left_q != 4'h0 && mode_4x) ? ~sb_val_q : 1'b1;
endmodule

`default_nettype wire

// File: test_agp_target_flow_status_strobes.sv
// Self-checking bench for the target flow, status and strobe block.
// Assumes the master model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module test_agp_target_flow_status_strobes import aft_pkg::*;;
    localparam int XF = 4;
    logic clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, mode_4x = 1'b0, sb_rate_en = 1'b0;
    logic rd_full = 1'b0, wr_full = 1'b0, sb_go = 1'b0, rd_n, wr_n, lo_p, lo_cp, hi_p, hi_cp, sb_p, sb_cp;
    aft_kind_type req_kind = K_START;
    logic req_ready, xfer_done, bus_grant_n, lo_o, lo_oe, lo_co, lo_coe, hi_o, hi_oe, hi_co, hi_coe;
    logic [2:0] arb_status_code, strobe_seen, last_code;
    int fail_count = 0, checked = 0, grants = 0, oe_cyc = 0, comp_cyc = 0, bad = 0, dones = 0;
    int seen_lo = 0, seen_hi = 0, seen_sb = 0;
    int seed = 32'hE3BDA852;
    aft_kind_type kinds [6] = '{K_LP_RD, K_HP_RD, K_LP_WR, K_HP_WR, K_FAST_WR, K_START};

    always #5 clk = ~clk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end

    aft_target #(.XFER_CLKS(XF)) u_aft_target (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
        .req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready), .xfer_done(xfer_done),
        .mode_4x(mode_4x), .sb_rate_en(sb_rate_en), .rd_buf_full_n(rd_n), .wr_buf_full_n(wr_n),
        .arb_status_code(arb_status_code), .bus_grant_n(bus_grant_n), .ad_strobe_lo_i(lo_p),
        .ad_strobe_lo_o(lo_o), .ad_strobe_lo_oe(lo_oe), .ad_strobe_lo_comp_i(lo_cp),
        .ad_strobe_lo_comp_o(lo_co), .ad_strobe_lo_comp_oe(lo_coe), .ad_strobe_hi_i(hi_p),
        .ad_strobe_hi_o(hi_o), .ad_strobe_hi_oe(hi_oe), .ad_strobe_hi_comp_i(hi_cp),
        .ad_strobe_hi_comp_o(hi_co), .ad_strobe_hi_comp_oe(hi_coe), .sideband_strobe(sb_p),
        .sideband_strobe_comp(sb_cp), .strobe_seen(strobe_seen));

    aft_master_model #(.BURST(XF)) u_aft_master_model (.link_clk(link_clk), .arst_n(arst_n),
        .bus_grant_n(bus_grant_n), .arb_status_code(arb_status_code), .mode_4x(mode_4x),
        .rd_full_cmd(rd_full), .wr_full_cmd(wr_full), .sb_go(sb_go), .lo_o(lo_o), .lo_oe(lo_oe),
        .lo_c_o(lo_co), .lo_c_oe(lo_coe), .hi_o(hi_o), .hi_oe(hi_oe), .hi_c_o(hi_co), .hi_c_oe(hi_coe),
        .rd_buf_full_n(rd_n), .wr_buf_full_n(wr_n), .lo_pin(lo_p), .lo_c_pin(lo_cp), .hi_pin(hi_p),
        .hi_c_pin(hi_cp), .sb_pin(sb_p), .sb_c_pin(sb_cp));

    ////////////////////////////////////////////////////////////////////////
    // Link-side monitor; counters only grow, tasks take differences
    always @(posedge link_clk) begin
        if (bus_grant_n === 1'b0) begin
            grants++;
            last_code = arb_status_code;
            if (arb_status_code inside {3'h4, 3'h5, 3'h6}) bad++;
        end
        if (lo_oe === 1'b1 && hi_oe === 1'b1) oe_cyc++;
        if (lo_oe !== hi_oe || (lo_coe === 1'b1 && lo_co !== ~lo_o)) bad++;
        if (lo_coe === 1'b1 && hi_coe === 1'b1) comp_cyc++;
        seen_lo += (strobe_seen[0] === 1'b1);
        seen_hi += (strobe_seen[1] === 1'b1);
        seen_sb += (strobe_seen[2] === 1'b1);
    end
    always @(posedge clk) if (xfer_done === 1'b1) dones++;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches=%0d comparisons=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    function automatic logic [2:0] exp_code(input aft_kind_type k);
        case (k)
            K_LP_RD: return 3'h0;
            K_HP_RD: return 3'h1;
            K_LP_WR: return 3'h2;
            K_HP_WR: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction

    // Request is taken at the first edge since ready is high between operations
    task automatic send(input aft_kind_type k);
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind <= k;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask

    task automatic wait_done(input int lim, output bit ok);
        int d0;
        d0 = dones;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = (dones > d0);
        end
    endtask

    task automatic do_op(input aft_kind_type k);
        int g, o, c, l, h;
        bit ok, dev, mst;
        g = grants;
        o = oe_cyc;
        c = comp_cyc;
        l = seen_lo;
        h = seen_hi;
        dev = k inside {K_LP_RD, K_HP_RD, K_FAST_WR};
        mst = k inside {K_LP_WR, K_HP_WR};
        send(k);
        wait_done(3000, ok);
        repeat (6) @(posedge link_clk);
        check(ok, 1);
        check(grants - g, (k == K_FAST_WR) ? 0 : 1);
        if (k != K_FAST_WR) check(last_code, exp_code(k));
        check(oe_cyc - o, dev ? XF : 0);
        check(comp_cyc - c, (dev && mode_4x) ? XF : 0);
        check(seen_lo - l, mst ? XF : 0);
        check(seen_hi - h, mst ? XF : 0);
    endtask

    // Flag raised before the request: no transfer until it clears
    task automatic blocked(input aft_kind_type k, input bit rd);
        int g, o;
        bit ok;
        @(posedge clk);
        rd_full <= rd;
        wr_full <= !rd;
        repeat (4) @(posedge link_clk);
        g = grants;
        o = oe_cyc;
        send(k);
        wait_done(400, ok);
        check(ok, 0);
        check(oe_cyc - o + grants - g, 0);
        @(posedge clk);
        rd_full <= 1'b0;
        wr_full <= 1'b0;
        wait_done(3000, ok);
        repeat (6) @(posedge link_clk);
        check(ok, 1);
        check(oe_cyc - o, XF);
    endtask

    // Flag raised once data has started: the running transfer completes whole
    task automatic mid_flip(input aft_kind_type k, input bit rd);
        int o;
        bit ok;
        o = oe_cyc;
        send(k);
        for (int i = 0; i < 200 && oe_cyc == o; i++) @(posedge link_clk);
        @(posedge clk);
        rd_full <= rd;
        wr_full <= !rd;
        wait_done(3000, ok);
        repeat (6) @(posedge link_clk);
        check(ok, 1);
        check(oe_cyc - o, XF);
        @(posedge clk);
        rd_full <= 1'b0;
        wr_full <= 1'b0;
        repeat (4) @(posedge link_clk);
    endtask

    // Sideband burst, counted only once the rate is configured
    task automatic sb_burst(input bit en);
        int s;
        @(posedge clk);
        sb_rate_en <= en;
        repeat (4) @(posedge link_clk);
        s = seen_sb;
        @(posedge clk);
        sb_go <= 1'b1;
        repeat (XF + 8) @(posedge link_clk);
        @(posedge clk);
        sb_go <= 1'b0;
        check(seen_sb - s, en ? XF : 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #900000;
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({req_ready, xfer_done, bus_grant_n, arb_status_code}, 6'h2F);
        check({lo_oe, hi_oe, lo_coe, hi_coe, strobe_seen}, 7'h00);
        repeat (4) @(posedge link_clk);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            mode_4x <= m[0];
            repeat (4) @(posedge link_clk);
            foreach (kinds[i]) do_op(kinds[i]);
        end
        blocked(K_LP_RD, 1'b1);
        blocked(K_FAST_WR, 1'b0);
        @(posedge clk);
        rd_full <= 1'b1;
        repeat (4) @(posedge link_clk);
        do_op(K_HP_RD); // high priority passes a full read buffer
        @(posedge clk);
        rd_full <= 1'b0;
        mid_flip(K_LP_RD, 1'b1);
        mid_flip(K_FAST_WR, 1'b0);
        sb_burst(1'b0);
        sb_burst(1'b1);
        for (int n = 0; n < 30; n++) begin
            @(posedge clk);
            mode_4x <= 1'($random(seed));
            repeat (4) @(posedge link_clk);
            do_op(kinds[{$random(seed)} % 6]);
        end
        check(bad, 0);
        complete_run();
    end
endmodule

`default_nettype wire
